// ### mcr_pkg.sv
// package: address map, reset values and state layout of the memory controller register bank
package mcr_pkg;
    localparam int MC_COUNT = 8;
    localparam int ADDR_W = 22;
    localparam int LOCAL_W = 17;
    localparam int REGION_W = 5;
    localparam logic [1:0] REGION_TOP = 2'h1; // every controller code starts 01
    // local offsets
    localparam logic [16:0] OFS_CORRECT_EN = 17'h05800;
    localparam logic [16:0] OFS_SCRUB_EN = 17'h05804;
    localparam logic [16:0] OFS_SCRUB_INTERVAL = 17'h05810;
    localparam logic [16:0] OFS_COUNTER_CLEAR = 17'h05818;
    localparam logic [16:0] OFS_SINGLE_CNT_PC0 = 17'h05828;
    localparam logic [16:0] OFS_DOUBLE_CNT_PC0 = 17'h0582c;
    localparam logic [16:0] OFS_SINGLE_CNT_PC1 = 17'h05834;
    localparam logic [16:0] OFS_DOUBLE_CNT_PC1 = 17'h05838;
    localparam logic [16:0] OFS_INJ_SINGLE_PC0 = 17'h0584c;
    localparam logic [16:0] OFS_INJ_DOUBLE_PC0 = 17'h05850;
    localparam logic [16:0] OFS_INJ_SINGLE_PC1 = 17'h05854;
    localparam logic [16:0] OFS_INJ_DOUBLE_PC1 = 17'h05858;
    localparam logic [16:0] OFS_SINGLE_THRESHOLD = 17'h0585c;
    localparam logic [16:0] OFS_THR_FLAG_PC0 = 17'h05864;
    localparam logic [16:0] OFS_THR_FLAG_PC1 = 17'h05868;
    localparam logic [16:0] OFS_PHY_INIT_DONE = 17'h10034;
    localparam logic [16:0] OFS_OVERTEMP_TRIP = 17'h1004c;
    localparam logic [16:0] OFS_MON_REPEAT = 17'h13800;
    localparam logic [16:0] OFS_MON_SINGLE = 17'h13804;
    localparam logic [16:0] OFS_MON_INTERVAL = 17'h13808;
    localparam logic [16:0] OFS_MON_DONE = 17'h1380c;
    // reset values and counts
    localparam logic RST_CORRECT_EN = 1'h1;
    localparam logic [12:0] RST_SCRUB_INTERVAL = 13'h0002;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam int SCRUB_UNIT_SHIFT = 8; // 256 memory clocks per interval unit

    typedef struct packed {
        logic [3:0] inj1;
        logic [3:0] inj2;
        logic [3:0] arm1;
        logic [3:0] arm2;
        logic [7:0] cnt1;
        logic [7:0] cnt2;
        logic [7:0] seen;
        logic tflag;
    } mcr_pc_s;

    typedef struct packed {
        logic corr_en;
        logic scrub_en;
        logic [12:0] scrub_per;
        logic err_clr;
        logic [7:0] thr;
        mcr_pc_s [1:0] pc;
        logic [20:0] scrub_cnt;
        logic scrub_rd;
        logic init_s1;
        logic init_s2;
        logic init_done;
        logic trip_s1;
        logic trip_s2;
        logic trip;
        logic mon_rep;
        logic [31:0] mon_int;
        logic [31:0] mon_cnt;
        logic mon_run;
        logic mon_done;
        logic mon_latch;
    } mcr_mc_s;

    typedef struct packed {
        mcr_mc_s [MC_COUNT-1:0] mc;
        logic [31:0] rdata;
        logic slverr;
    } mcr_state_s;
endpackage

// ### mcr_regs.sv
// register bank of one memory stack: ecc control, counters, status and activity monitor
// Notes on behaviour
// - one register port per stack, decoding its own private 22-bit space
// - top five address bits pick a region, low 17 bits a register
// - controllers 0..7 use region codes 01000,01100,01001,01101,01010,01110,01011,01111
// - per pseudo channel registers exist twice, channel 0 and 1 offsets
// - correction enable turns on single correct, double detect; resets to one
// - scrubbing runs only while scrub enable and correction enable are both set
// - scrub reads spaced by interval field times 256 clocks; field resets to 2
// - 4-bit single and double injection fields per channel pick burst beats
// - 8-bit single error counter per channel, saturates at 255, resets zero
// - 8-bit double error counter per channel, saturates, cleared by clear control
// - while clear bit is one counters stay zero; counting resumes after
// - flag and single counter start only once errors exceed the threshold
// - threshold flag per channel sets on exceeding, clears when read
// - phy init status reads one after initialization completes, zero after reset
// - over-temperature status is sticky once the catastrophic limit trips
// - activity monitor registers are 32 bits wide
// - repeat mode collects, latches at interval end and restarts by itself
// - single mode collects one interval, latches, then stops
// - monitor interval is a 32-bit count of memory clocks
// - writing one to single start launches one interval
// - done flag sets at interval end, clears itself once read as one
`timescale 1ns/1ps
`default_nettype none
module mcr_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [21:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [mcr_pkg::MC_COUNT-1:0] ecc_correct_enable,
    output logic [mcr_pkg::MC_COUNT-1:0] scrub_read,
    input wire logic [mcr_pkg::MC_COUNT-1:0][1:0] write_burst,
    output logic [mcr_pkg::MC_COUNT-1:0][1:0][3:0] inject_single_beats,
    output logic [mcr_pkg::MC_COUNT-1:0][1:0][3:0] inject_double_beats,
    input wire logic [mcr_pkg::MC_COUNT-1:0][1:0] single_err_event,
    input wire logic [mcr_pkg::MC_COUNT-1:0][1:0] double_err_event,
    input wire logic [mcr_pkg::MC_COUNT-1:0] phy_init_pin,
    input wire logic [mcr_pkg::MC_COUNT-1:0] overtemp_pin,
    output logic [mcr_pkg::MC_COUNT-1:0] monitor_active,
    output logic [mcr_pkg::MC_COUNT-1:0] monitor_latch
);
    mcr_pkg::mcr_state_s state_reg;
    mcr_pkg::mcr_state_s state_next;

    // ****************************************
    // address decode
    // ****************************************
    logic [4:0] region;
    logic [16:0] ofs;
    logic region_ok;
    logic [2:0] sel;
    logic setup;
    logic access;
    assign region = paddr[21:17];
    assign ofs = paddr[16:0];
    assign region_ok = (region[4:3] == mcr_pkg::REGION_TOP);
    assign sel = {region[1], region[0], region[2]};
    assign setup = psel && !penable;
    assign access = psel && penable;

    // the port never waits; data and error are prepared in the setup phase
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = state_reg.slverr;

    // controller-facing outputs straight from state
    always_comb begin
        for (int i = 0; i < mcr_pkg::MC_COUNT; i++) begin
            ecc_correct_enable[i] = state_reg.mc[i].corr_en;
            scrub_read[i] = state_reg.mc[i].scrub_rd;
            monitor_active[i] = state_reg.mc[i].mon_run;
            monitor_latch[i] = state_reg.mc[i].mon_latch;
            for (int p = 0; p < 2; p++) begin
                inject_single_beats[i][p] = state_reg.mc[i].pc[p].arm1;
                inject_double_beats[i][p] = state_reg.mc[i].pc[p].arm2;
            end
        end
    end

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic hit;
        logic known;
        logic wr;
        logic [31:0] rd;
        logic [20:0] target;
        logic [31:0] span;
        logic [7:0] n;
        state_next = state_reg;
        hit = 1'b0;
        known = 1'b0;
        wr = 1'b0;
        rd = 32'h0000_0000;
        target = 21'h000000;
        span = 32'h0000_0000;
        n = 8'h00;
        for (int i = 0; i < mcr_pkg::MC_COUNT; i++) begin
            hit = region_ok && (sel == 3'(i));
            wr = access && pwrite && hit;
            // pins from outside the clock domain pass two flops
            state_next.mc[i].init_s1 = phy_init_pin[i];
            state_next.mc[i].init_s2 = state_reg.mc[i].init_s1;
            state_next.mc[i].trip_s1 = overtemp_pin[i];
            state_next.mc[i].trip_s2 = state_reg.mc[i].trip_s1;
            if (state_reg.mc[i].init_s2) begin
                state_next.mc[i].init_done = 1'b1;
            end
            if (state_reg.mc[i].trip_s2) begin
                state_next.mc[i].trip = 1'b1;
            end
            // scrub read spacing; a zero interval scrubs every clock
            target = {state_reg.mc[i].scrub_per, 8'h00};
            state_next.mc[i].scrub_rd = 1'b0;
            if (state_reg.mc[i].scrub_en && state_reg.mc[i].corr_en) begin
                if (21'(state_reg.mc[i].scrub_cnt + 21'h1) >= target) begin
                    state_next.mc[i].scrub_rd = 1'b1;
                    state_next.mc[i].scrub_cnt = 21'h000000;
                end else begin
                    state_next.mc[i].scrub_cnt = 21'(state_reg.mc[i].scrub_cnt + 21'h1);
                end
            end else begin
                state_next.mc[i].scrub_cnt = 21'h000000;
            end
            // per channel error counting and injection
            for (int p = 0; p < 2; p++) begin
                // a write burst consumes the armed beats
                if (write_burst[i][p]) begin
                    state_next.mc[i].pc[p].arm1 = 4'h0;
                    state_next.mc[i].pc[p].arm2 = 4'h0;
                end
                if (state_reg.mc[i].err_clr) begin
                    state_next.mc[i].pc[p].cnt1 = 8'h00;
                    state_next.mc[i].pc[p].cnt2 = 8'h00;
                    state_next.mc[i].pc[p].seen = 8'h00;
                end else begin
                    if (double_err_event[i][p] && state_reg.mc[i].pc[p].cnt2 != mcr_pkg::CNT_MAX) begin
                        state_next.mc[i].pc[p].cnt2 = 8'(state_reg.mc[i].pc[p].cnt2 + 8'h1);
                    end
                    if (single_err_event[i][p]) begin
                        n = state_reg.mc[i].pc[p].seen;
                        if (n != mcr_pkg::CNT_MAX) begin
                            n = 8'(n + 8'h1);
                        end
                        state_next.mc[i].pc[p].seen = n;
                        // only errors past the threshold are counted and flagged
                        if (n > state_reg.mc[i].thr) begin
                            if (state_reg.mc[i].pc[p].cnt1 != mcr_pkg::CNT_MAX) begin
                                state_next.mc[i].pc[p].cnt1 = 8'(state_reg.mc[i].pc[p].cnt1 + 8'h1);
                            end
                        end
                    end
                end
            end
            // activity monitor interval; zero behaves as one clock
            span = (state_reg.mc[i].mon_int == 32'h0) ? 32'h1 : state_reg.mc[i].mon_int;
            state_next.mc[i].mon_latch = 1'b0;
            if (state_reg.mc[i].mon_run) begin
                if (32'(state_reg.mc[i].mon_cnt + 32'h1) >= span) begin
                    state_next.mc[i].mon_latch = 1'b1;
                    state_next.mc[i].mon_cnt = 32'h0;
                    state_next.mc[i].mon_run = state_reg.mc[i].mon_rep;
                end else begin
                    state_next.mc[i].mon_cnt = 32'(state_reg.mc[i].mon_cnt + 32'h1);
                end
            end
            // register writes in the access phase
            if (wr) begin
                case (ofs)
                    mcr_pkg::OFS_CORRECT_EN: state_next.mc[i].corr_en = pwdata[0];
                    mcr_pkg::OFS_SCRUB_EN: state_next.mc[i].scrub_en = pwdata[0];
                    mcr_pkg::OFS_SCRUB_INTERVAL: state_next.mc[i].scrub_per = pwdata[12:0];
                    mcr_pkg::OFS_COUNTER_CLEAR: state_next.mc[i].err_clr = pwdata[0];
                    mcr_pkg::OFS_SINGLE_THRESHOLD: state_next.mc[i].thr = pwdata[7:0];
                    mcr_pkg::OFS_MON_INTERVAL: state_next.mc[i].mon_int = pwdata;
                    mcr_pkg::OFS_MON_REPEAT: begin
                        state_next.mc[i].mon_rep = pwdata[0];
                        if (pwdata[0] && !state_reg.mc[i].mon_run) begin
                            state_next.mc[i].mon_run = 1'b1;
                            state_next.mc[i].mon_cnt = 32'h0;
                        end
                    end
                    mcr_pkg::OFS_MON_SINGLE: begin
                        // a start while running is ignored
                        if (pwdata[0] && !state_reg.mc[i].mon_run) begin
                            state_next.mc[i].mon_run = 1'b1;
                            state_next.mc[i].mon_cnt = 32'h0;
                        end
                    end
                    default: begin
                    end
                endcase
                for (int p = 0; p < 2; p++) begin
                    // arm only the bits that rise, so a held bit injects once
                    if (ofs == (p == 0 ? mcr_pkg::OFS_INJ_SINGLE_PC0 : mcr_pkg::OFS_INJ_SINGLE_PC1)) begin
                        state_next.mc[i].pc[p].inj1 = pwdata[3:0];
                        state_next.mc[i].pc[p].arm1 = state_next.mc[i].pc[p].arm1
                            | (pwdata[3:0] & ~state_reg.mc[i].pc[p].inj1);
                    end
                    if (ofs == (p == 0 ? mcr_pkg::OFS_INJ_DOUBLE_PC0 : mcr_pkg::OFS_INJ_DOUBLE_PC1)) begin
                        state_next.mc[i].pc[p].inj2 = pwdata[3:0];
                        state_next.mc[i].pc[p].arm2 = state_next.mc[i].pc[p].arm2
                            | (pwdata[3:0] & ~state_reg.mc[i].pc[p].inj2);
                    end
                end
            end
            // read-clear flags: cleared only if the value returned was one; a new set wins
            for (int p = 0; p < 2; p++) begin
                if (access && !pwrite && hit && state_reg.rdata[0]
                    && ofs == (p == 0 ? mcr_pkg::OFS_THR_FLAG_PC0 : mcr_pkg::OFS_THR_FLAG_PC1)) begin
                    state_next.mc[i].pc[p].tflag = 1'b0;
                end
                if (!state_reg.mc[i].err_clr && single_err_event[i][p]
                    && state_next.mc[i].pc[p].seen > state_reg.mc[i].thr) begin
                    state_next.mc[i].pc[p].tflag = 1'b1;
                end
            end
            if (access && !pwrite && hit && state_reg.rdata[0] && ofs == mcr_pkg::OFS_MON_DONE) begin
                state_next.mc[i].mon_done = 1'b0;
            end
            if (state_next.mc[i].mon_latch) begin
                state_next.mc[i].mon_done = 1'b1;
            end
        end
        // read data and error are captured in the setup phase
        if (setup) begin
            known = 1'b1;
            for (int i = 0; i < mcr_pkg::MC_COUNT; i++) begin
                if (region_ok && sel == 3'(i)) begin
                    case (ofs)
                        mcr_pkg::OFS_CORRECT_EN: rd = {31'h0, state_reg.mc[i].corr_en};
                        mcr_pkg::OFS_SCRUB_EN: rd = {31'h0, state_reg.mc[i].scrub_en};
                        mcr_pkg::OFS_SCRUB_INTERVAL: rd = {19'h0, state_reg.mc[i].scrub_per};
                        mcr_pkg::OFS_COUNTER_CLEAR: rd = {31'h0, state_reg.mc[i].err_clr};
                        mcr_pkg::OFS_SINGLE_CNT_PC0: rd = {24'h0, state_reg.mc[i].pc[0].cnt1};
                        mcr_pkg::OFS_DOUBLE_CNT_PC0: rd = {24'h0, state_reg.mc[i].pc[0].cnt2};
                        mcr_pkg::OFS_SINGLE_CNT_PC1: rd = {24'h0, state_reg.mc[i].pc[1].cnt1};
                        mcr_pkg::OFS_DOUBLE_CNT_PC1: rd = {24'h0, state_reg.mc[i].pc[1].cnt2};
                        mcr_pkg::OFS_INJ_SINGLE_PC0: rd = {28'h0, state_reg.mc[i].pc[0].inj1};
                        mcr_pkg::OFS_INJ_DOUBLE_PC0: rd = {28'h0, state_reg.mc[i].pc[0].inj2};
                        mcr_pkg::OFS_INJ_SINGLE_PC1: rd = {28'h0, state_reg.mc[i].pc[1].inj1};
                        mcr_pkg::OFS_INJ_DOUBLE_PC1: rd = {28'h0, state_reg.mc[i].pc[1].inj2};
                        mcr_pkg::OFS_SINGLE_THRESHOLD: rd = {24'h0, state_reg.mc[i].thr};
                        mcr_pkg::OFS_THR_FLAG_PC0: rd = {31'h0, state_reg.mc[i].pc[0].tflag};
                        mcr_pkg::OFS_THR_FLAG_PC1: rd = {31'h0, state_reg.mc[i].pc[1].tflag};
                        mcr_pkg::OFS_PHY_INIT_DONE: rd = {31'h0, state_reg.mc[i].init_done};
                        mcr_pkg::OFS_OVERTEMP_TRIP: rd = {31'h0, state_reg.mc[i].trip};
                        mcr_pkg::OFS_MON_REPEAT: rd = {31'h0, state_reg.mc[i].mon_rep};
                        mcr_pkg::OFS_MON_SINGLE: rd = 32'h0;
                        mcr_pkg::OFS_MON_INTERVAL: rd = state_reg.mc[i].mon_int;
                        mcr_pkg::OFS_MON_DONE: rd = {31'h0, state_reg.mc[i].mon_done};
                        default: known = 1'b0;
                    endcase
                end
            end
            if (!region_ok) begin
                known = 1'b0; // unmapped region answers with an error
            end
            state_next.rdata = rd;
            state_next.slverr = !known;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            for (int i = 0; i < mcr_pkg::MC_COUNT; i++) begin
                state_reg.mc[i].corr_en <= mcr_pkg::RST_CORRECT_EN;
                state_reg.mc[i].scrub_per <= mcr_pkg::RST_SCRUB_INTERVAL;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // checks on controller 0, plus the unmapped-region error check
    // ****************************************
    sequence s_read_access;
        psel && penable && !pwrite;
    endsequence

    property p_scrub_gate;
        @(posedge clk) disable iff (!nrst)
        scrub_read[0] |-> $past(state_reg.mc[0].scrub_en && state_reg.mc[0].corr_en);
    endproperty
    a_scrub_gate: assert property (p_scrub_gate) else $error("scrub read while disabled");

    property p_clear_hold;
        @(posedge clk) disable iff (!nrst)
        state_reg.mc[0].err_clr |=> state_reg.mc[0].pc[0].cnt1 == 8'h00 && state_reg.mc[0].pc[0].cnt2 == 8'h00;
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("counter moved under clear");

    property p_single_sat;
        @(posedge clk) disable iff (!nrst)
        state_reg.mc[0].pc[0].cnt1 == 8'hff && !state_reg.mc[0].err_clr |=> state_reg.mc[0].pc[0].cnt1 == 8'hff;
    endproperty
    a_single_sat: assert property (p_single_sat) else $error("single counter wrapped");

    property p_flag_cause;
        @(posedge clk) disable iff (!nrst)
        $rose(state_reg.mc[0].pc[0].tflag) |-> $past(single_err_event[0][0]) && state_reg.mc[0].pc[0].seen > state_reg.mc[0].thr;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set below threshold");

    property p_flag_read_clear;
        @(posedge clk) disable iff (!nrst)
        (s_read_access and (region_ok && sel == 3'h0 && ofs == mcr_pkg::OFS_THR_FLAG_PC0
            && prdata[0] && !single_err_event[0][0])) |=> !state_reg.mc[0].pc[0].tflag;
    endproperty
    a_flag_read_clear: assert property (p_flag_read_clear) else $error("flag not cleared by read");

    property p_inject_once;
        @(posedge clk) disable iff (!nrst)
        $fell(inject_single_beats[0][0] != 4'h0) |-> $past(write_burst[0][0]);
    endproperty
    a_inject_once: assert property (p_inject_once) else $error("armed beats lost without burst");

    property p_done_after_latch;
        @(posedge clk) disable iff (!nrst)
        monitor_latch[0] |-> ##1 state_reg.mc[0].mon_done;
    endproperty
    a_done_after_latch: assert property (p_done_after_latch) else $error("done flag missing");

    property p_mode_after_latch;
        @(posedge clk) disable iff (!nrst)
        monitor_latch[0] |=> monitor_active[0] == $past(state_reg.mc[0].mon_rep);
    endproperty
    a_mode_after_latch: assert property (p_mode_after_latch) else $error("wrong mode after interval");

    property p_unmapped_err;
        @(posedge clk) disable iff (!nrst)
        psel && !penable && !region_ok |=> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped region accepted");
endmodule
`default_nettype wire

// ### mcr_host.sv
// apb host model that drives the register port of one stack
`timescale 1ns/1ps
`default_nettype none
module mcr_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [21:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // idle bus until the first transfer
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 22'h0;
        pwdata = 32'h0;
    end
    // setup edge, access edge, answer taken on the edge after; bus then released
    task automatic xfer(input logic w, input logic [21:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        paddr <= ~a; // stale address is inverted, so nothing leans on it
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### mcr_regs_tb.sv
// self-checking bench for the stack register bank
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [21:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] ece, scr, mact, mlat;
    logic [7:0] phy = 8'h00;
    logic [7:0] trip = 8'h00;
    logic [7:0][1:0] wb = '0;
    logic [7:0][1:0] se = '0;
    logic [7:0][1:0] de = '0;
    logic [7:0][1:0][3:0] inj1, inj2;
    logic [4:0] code [8] = '{5'h08, 5'h0c, 5'h09, 5'h0d, 5'h0a, 5'h0e, 5'h0b, 5'h0f};
    logic [16:0] zofs [5] = '{mcr_pkg::OFS_COUNTER_CLEAR, mcr_pkg::OFS_DOUBLE_CNT_PC1,
        mcr_pkg::OFS_INJ_SINGLE_PC1, mcr_pkg::OFS_THR_FLAG_PC1, mcr_pkg::OFS_OVERTEMP_TRIP};
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int mc, t, k, n, v;
    mcr_regs dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ecc_correct_enable(ece), .scrub_read(scr), .write_burst(wb), .inject_single_beats(inj1),
        .inject_double_beats(inj2), .single_err_event(se), .double_err_event(de),
        .phy_init_pin(phy), .overtemp_pin(trip), .monitor_active(mact), .monitor_latch(mlat));
    mcr_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ****************************************
    // compare, bus and event helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int m, input logic [16:0] o, input logic [31:0] d);
        host.xfer(1'b1, {code[m], o}, d, rd, err);
    endtask
    task automatic rc(input int m, input logic [16:0] o, input logic [31:0] e);
        host.xfer(1'b0, {code[m], o}, 32'h0, rd, err);
        chk(rd, e);
        chk({pready, err}, 32'h2);
    endtask
    // one-cycle error pulses with a gap, like separate detected reads
    task automatic pulse(input int p, input bit dbl, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            de[mc][p] <= dbl;
            se[mc][p] <= !dbl;
            @(posedge clk);
            {de, se} <= '0;
        end
    endtask
    task automatic count(input int len, input bit lat);
        v = 0;
        repeat (len) begin
            @(negedge clk);
            v += lat ? mlat[mc] : scr[mc];
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // main sequence; expectations come from integer bookkeeping below
    initial begin
        v = $urandom(51);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        chk(ece, 32'hff);
        // the design's per-controller assertions watch controller 0, so the deep scenarios run there
        mc = 0;
        k = $urandom_range(1);
        rc(mc, mcr_pkg::OFS_CORRECT_EN, 32'h1);
        rc(mc, mcr_pkg::OFS_SCRUB_INTERVAL, 32'h2);
        foreach (zofs[i]) rc(mc, zofs[i], 32'h0);
        for (int m = 0; m < 8; m++) wr(m, mcr_pkg::OFS_SCRUB_INTERVAL, v + m);
        for (int m = 0; m < 8; m++) rc(m, mcr_pkg::OFS_SCRUB_INTERVAL, (v + m) & 32'h1fff);
        host.xfer(1'b0, {5'h10, mcr_pkg::OFS_CORRECT_EN}, 32'h0, rd, err);
        chk(err, 32'h1);
        host.xfer(1'b0, {code[$urandom_range(7)], 17'h00000}, 32'h0, rd, err);
        chk({rd[0], err}, 32'h1);
        t = $urandom_range(5, 1);
        n = $urandom_range(6, 1);
        wr(mc, mcr_pkg::OFS_SINGLE_THRESHOLD, t);
        wr(mc, mcr_pkg::OFS_SINGLE_CNT_PC0 + 17'h0000c * k, 32'h55);
        pulse(k, 0, t);
        rc(mc, mcr_pkg::OFS_THR_FLAG_PC0 + 17'h00004 * k, 32'h0);
        pulse(k, 0, n);
        rc(mc, mcr_pkg::OFS_SINGLE_CNT_PC0 + 17'h0000c * k, n);
        rc(mc, mcr_pkg::OFS_THR_FLAG_PC0 + 17'h00004 * k, 32'h1);
        rc(mc, mcr_pkg::OFS_THR_FLAG_PC0 + 17'h00004 * k, 32'h0);
        rc(mc, mcr_pkg::OFS_SINGLE_CNT_PC1 - 17'h0000c * k, 32'h0);
        pulse(k, 1, 3);
        rc(mc, mcr_pkg::OFS_DOUBLE_CNT_PC0 + 17'h0000c * k, 32'h3);
        wr(mc, mcr_pkg::OFS_COUNTER_CLEAR, 32'h1);
        pulse(k, 1, 2);
        rc(mc, mcr_pkg::OFS_DOUBLE_CNT_PC0 + 17'h0000c * k, 32'h0);
        wr(mc, mcr_pkg::OFS_COUNTER_CLEAR, 32'h0);
        wr(mc, mcr_pkg::OFS_SINGLE_THRESHOLD, 32'h0);
        pulse(k, 0, 260);
        rc(mc, mcr_pkg::OFS_SINGLE_CNT_PC0 + 17'h0000c * k, 32'hff);
        // arm, consume by a burst, then re-arm only through a low write
        wr(mc, mcr_pkg::OFS_INJ_SINGLE_PC0, n);
        wr(mc, mcr_pkg::OFS_INJ_DOUBLE_PC1, 32'hf - n);
        count(2, 0);
        chk({inj1[mc][0], inj2[mc][1]}, (n << 4) | (15 - n));
        @(posedge clk);
        wb[mc] <= 2'h3;
        @(posedge clk);
        wb <= '0;
        wr(mc, mcr_pkg::OFS_INJ_SINGLE_PC0, n);
        count(2, 0);
        chk({inj1[mc][0], inj2[mc][1]}, 32'h0);
        wr(mc, mcr_pkg::OFS_INJ_SINGLE_PC0, 32'h0);
        wr(mc, mcr_pkg::OFS_INJ_SINGLE_PC0, n);
        count(2, 0);
        chk(inj1[mc][0], n);
        // scrub spacing 1 x 256 clocks, then stopped by correction off
        wr(mc, mcr_pkg::OFS_SCRUB_INTERVAL, 32'h1);
        wr(mc, mcr_pkg::OFS_SCRUB_EN, 32'h1);
        for (int i = 0; i < 600 && scr[mc] !== 1'b1; i++) @(negedge clk);
        count(255, 0);
        chk(v, 32'h0);
        count(1, 0);
        chk(v, 32'h1);
        wr(mc, mcr_pkg::OFS_CORRECT_EN, 32'h0);
        count(600, 0);
        chk(v + ece[mc], 32'h0);
        // monitor: wide interval register, single run, repeat run
        wr(mc, mcr_pkg::OFS_MON_INTERVAL, v ^ 32'ha5c3f00f);
        rc(mc, mcr_pkg::OFS_MON_INTERVAL, v ^ 32'ha5c3f00f);
        wr(mc, mcr_pkg::OFS_MON_INTERVAL, 32'h4);
        wr(mc, mcr_pkg::OFS_MON_SINGLE, 32'h1);
        count(60, 1);
        chk({mact[mc], v[7:0]}, 32'h1);
        rc(mc, mcr_pkg::OFS_MON_DONE, 32'h1);
        rc(mc, mcr_pkg::OFS_MON_DONE, 32'h0);
        wr(mc, mcr_pkg::OFS_MON_REPEAT, 32'h1);
        count(60, 1);
        chk(v >= 10 && mact[mc] === 1'b1, 32'h1);
        wr(mc, mcr_pkg::OFS_MON_REPEAT, 32'h0);
        count(20, 1);
        count(60, 1);
        chk(v, 32'h0);
        // status pins: init level and sticky over-temperature
        @(posedge clk);
        phy[mc] <= 1'b1;
        trip[mc] <= 1'b1;
        count(4, 0);
        @(posedge clk);
        trip <= 8'h00;
        count(4, 0);
        rc(mc, mcr_pkg::OFS_PHY_INIT_DONE, 32'h1);
        rc(mc, mcr_pkg::OFS_OVERTEMP_TRIP, 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
